// ===== src/tlic_regs.svh
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH
`define TLIC_VEC_HIGH 21'h000008
`define TLIC_VEC_LOW 21'h000018
`define TLIC_PC_W 21
`define TLIC_NSRC 8
`define TLIC_CTRL_HIGH_EN_BIT 7
`define TLIC_CTRL_LOW_EN_BIT 6
`define TLIC_RSTCTL_PRIO_BIT 7
`define TLIC_SYNC_STAGES 2
`endif

// ===== src/tlic_pkg.sv
package tlic_pkg;
    typedef enum logic [1:0] {
        TLIC_IDLE,
        TLIC_IN_LOW,
        TLIC_IN_HIGH,
        TLIC_IN_BOTH
    } tlic_level_e;
    typedef struct packed {
        logic take;
        logic high;
        logic [20:0] addr;
    } tlic_vector_s;
endpackage : tlic_pkg

// ===== src/tlic_sync.sv
`timescale 1ns/10ps
module tlic_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Asynchronous reset.
    input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
    output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_meta = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule : tlic_sync

// ===== src/tlic_edge.sv
`timescale 1ns/10ps
module tlic_edge #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Asynchronous reset.
    input wire logic [WIDTH-1:0] level, // Synchronised levels.
    input wire logic [WIDTH-1:0] rising, // One selects rising edge per bit.
    output logic [WIDTH-1:0] pulse // One-cycle edge pulses.
);
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_prev;
    logic [WIDTH-1:0] edge_hit;
    logic [1:0] arm_cnt;
    logic [1:0] next_arm_cnt;
    logic armed;

    // Edges count only once the synchroniser and the stored level both hold real pin levels.
    // Otherwise a pin that idles high would show a false rising edge just after reset.
    assign armed = (arm_cnt == 2'h3);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign edge_hit[i] = armed & (rising[i] ? (level[i] & ~prev[i]) : (~level[i] & prev[i]));
        end
    endgenerate

    always_comb begin
        next_prev = level;
        next_arm_cnt = armed ? arm_cnt : arm_cnt + 2'h1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev <= '0;
            arm_cnt <= 2'h0;
        end else begin
            prev <= next_prev;
            arm_cnt <= next_arm_cnt;
        end
    end

    assign pulse = edge_hit;
endmodule : tlic_edge

// ===== src/tlic_top.sv
`timescale 1ns/10ps
`include "tlic_regs.svh"
// How it works
// - Priority mode sends high requests to 0008h and low requests to 0018h.
// - A high request preempts a running low-level handler.
// - Each source has a flag, an enable and a priority select bit.
// - Two-level mode only while the priority mode enable bit is set; clear at reset.
// - In priority mode control bit 7 gates all high-priority sources.
// - In priority mode control bit 6 gates all low-priority sources.
// - Flag, enable and matching global enable together cause a vector at the next instruction boundary.
// - A cleared source enable blocks that source whatever the global enables.
// - Compatibility mode ignores every priority bit.
// - Compatibility mode: bit 6 gates peripheral sources, bit 7 gates all.
// - Compatibility mode vectors every accepted interrupt to 0008h.
// - Acceptance clears the global enable in use for that level or mode.
// - No low request is accepted while a high handler runs.
// - Vectoring pushes the return address and loads the vector address.
// - The return instruction leaves the handler and sets the cleared enable again.
// - Pin events reach the vector three to four instruction cycles later.
// - Flags set on every event regardless of any enable.
module tlic_top
    import tlic_pkg::*;
#(
    parameter int NSRC = `TLIC_NSRC,
    parameter int NPIN = 4
) (
    input wire logic clk_sys, // System clock, 10 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic instr_boundary, // One-cycle pulse at each instruction cycle boundary.
    input wire logic [NPIN-1:0] pin_event_in, // Raw external pin levels, sources 0 to NPIN-1.
    input wire logic [NPIN-1:0] pin_rising, // Edge select per pin, one for rising.
    input wire logic [NSRC-1:0] periph_event, // One-cycle peripheral event pulses, same clock.
    input wire logic [NSRC-1:0] src_is_periph, // One marks a source as peripheral.
    input wire logic [NSRC-1:0] src_enable, // Per-source enable bits.
    input wire logic [NSRC-1:0] src_priority, // Per-source priority, one for high.
    input wire logic [NSRC-1:0] flag_clear, // One-cycle software clear of flags.
    input wire logic priority_mode_enable, // Reset control register bit 7.
    input wire logic global_set_hi, // Software writes one to control bit 7.
    input wire logic global_clr_hi, // Software writes zero to control bit 7.
    input wire logic global_set_lo, // Software writes one to control bit 6.
    input wire logic global_clr_lo, // Software writes zero to control bit 6.
    input wire logic return_from_handler_instr, // One-cycle pulse when the return executes.
    input wire logic [`TLIC_PC_W-1:0] return_pc, // Address to push on vectoring.
    output logic [NSRC-1:0] src_flag, // Sticky event flags.
    output logic high_level_global_enable, // Control bit 7 state.
    output logic low_level_global_enable, // Control bit 6 state.
    output logic vector_take, // One-cycle pulse: load program counter.
    output logic [`TLIC_PC_W-1:0] vector_addr, // Vector address, held.
    output logic stack_push, // One-cycle pulse: push return address.
    output logic [`TLIC_PC_W-1:0] stack_push_data, // Return address pushed.
    output logic in_high_handler, // High-level handler active.
    output logic in_low_handler // Low-level handler active.
);
    import tlic_pkg::*;

    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] pin_pulse;
    logic [NPIN-1:0] pin_seen;
    logic [NPIN-1:0] pin_stage;
    logic [NPIN-1:0] next_pin_seen;
    logic [NPIN-1:0] next_pin_stage;
    logic [NPIN-1:0] pin_to_flag;
    logic [NSRC-1:0] event_all;
    logic [NSRC-1:0] next_src_flag;
    logic prio_mode;
    logic [NSRC-1:0] qual;
    logic req_hi;
    logic req_lo;
    tlic_vector_s sel;
    tlic_level_e level;
    tlic_level_e next_level;
    logic next_hi_en;
    logic next_lo_en;
    logic next_vector_take;
    logic [`TLIC_PC_W-1:0] next_vector_addr;
    logic next_stack_push;
    logic [`TLIC_PC_W-1:0] next_stack_push_data;
    logic [1:0] ret_stack;
    logic [1:0] next_ret_stack;

    tlic_sync #(.WIDTH(NPIN)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(pin_event_in),
        .sync_out(pin_sync)
    );

    tlic_edge #(.WIDTH(NPIN)) u_edge (
        .clk_sys(clk_sys),
        .rst(rst),
        .level(pin_sync),
        .rising(pin_rising),
        .pulse(pin_pulse)
    );

    // A pin edge waits in two stages that advance only at instruction boundaries.
    // Its flag rises at the second boundary and the vector follows at the third, so pin latency
    // stays at three to four instruction cycles whatever the core is executing.
    always_comb begin
        next_pin_seen = instr_boundary ? pin_pulse : (pin_seen | pin_pulse);
        next_pin_stage = instr_boundary ? pin_seen : pin_stage;
        pin_to_flag = instr_boundary ? pin_stage : '0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_seen <= '0;
            pin_stage <= '0;
        end else begin
            pin_seen <= next_pin_seen;
            pin_stage <= next_pin_stage;
        end
    end

    // Pin events merge into the low sources; peripheral pulses cover the rest.
    always_comb begin
        event_all = periph_event;
        event_all[NPIN-1:0] = periph_event[NPIN-1:0] | pin_to_flag;
    end

    // An event in the same cycle as a clear keeps the flag set.
    always_comb begin
        next_src_flag = (src_flag & ~flag_clear) | event_all;
    end

    assign prio_mode = priority_mode_enable;

    function automatic logic [NSRC-1:0] gate(input logic pm, input logic [NSRC-1:0] pri,
                                             input logic [NSRC-1:0] per, input logic hi, input logic lo);
        logic [NSRC-1:0] g;
        g = '0;
        for (int k = 0; k < NSRC; k++) begin
            if (pm) begin
                g[k] = pri[k] ? hi : lo;
            end else begin
                g[k] = hi & (per[k] ? lo : 1'b1);
            end
        end
        return g;
    endfunction : gate

    always_comb begin
        qual = src_flag & src_enable & gate(prio_mode, src_priority, src_is_periph,
                                            high_level_global_enable, low_level_global_enable);
        if (prio_mode) begin
            req_hi = |(qual & src_priority);
            req_lo = |(qual & ~src_priority) & ~in_high_handler;
        end else begin
            req_hi = |qual;
            req_lo = 1'b0;
        end
    end

    always_comb begin
        sel.take = instr_boundary & (req_hi | req_lo) & ~vector_take;
        sel.high = req_hi;
        if (prio_mode && !req_hi) begin
            sel.addr = `TLIC_VEC_LOW;
        end else begin
            sel.addr = `TLIC_VEC_HIGH;
        end
    end

    always_comb begin
        next_level = level;
        next_hi_en = high_level_global_enable;
        next_lo_en = low_level_global_enable;
        next_ret_stack = ret_stack;
        next_vector_take = 1'b0;
        next_vector_addr = vector_addr;
        next_stack_push = 1'b0;
        next_stack_push_data = stack_push_data;
        if (global_set_hi) next_hi_en = 1'b1;
        if (global_clr_hi) next_hi_en = 1'b0;
        if (global_set_lo) next_lo_en = 1'b1;
        if (global_clr_lo) next_lo_en = 1'b0;
        if (sel.take) begin
            next_vector_take = 1'b1;
            next_vector_addr = sel.addr;
            next_stack_push = 1'b1;
            next_stack_push_data = return_pc;
            if (!prio_mode || sel.high) begin
                next_hi_en = 1'b0;
            end else begin
                next_lo_en = 1'b0;
            end
            // Bit 0 holds the innermost handler; a one there means its return sets bit 7 again.
            next_ret_stack = {ret_stack[0], (!prio_mode || sel.high)};
            unique case (level)
                TLIC_IDLE: next_level = (prio_mode && !sel.high) ? TLIC_IN_LOW : TLIC_IN_HIGH;
                TLIC_IN_LOW: next_level = sel.high ? TLIC_IN_BOTH : TLIC_IN_LOW;
                TLIC_IN_HIGH: next_level = TLIC_IN_HIGH;
                TLIC_IN_BOTH: next_level = TLIC_IN_BOTH;
            endcase
        end else if (return_from_handler_instr) begin
            if (ret_stack[0]) begin
                next_hi_en = 1'b1;
            end else begin
                next_lo_en = 1'b1;
            end
            next_ret_stack = {1'b0, ret_stack[1]};
            unique case (level)
                TLIC_IDLE: next_level = TLIC_IDLE;
                TLIC_IN_LOW: next_level = TLIC_IDLE;
                TLIC_IN_HIGH: next_level = TLIC_IDLE;
                TLIC_IN_BOTH: next_level = TLIC_IN_LOW;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            src_flag <= '0;
            level <= TLIC_IDLE;
            high_level_global_enable <= 1'b0;
            low_level_global_enable <= 1'b0;
            ret_stack <= 2'h0;
            vector_take <= 1'b0;
            vector_addr <= `TLIC_VEC_HIGH;
            stack_push <= 1'b0;
            stack_push_data <= '0;
            in_high_handler <= 1'b0;
            in_low_handler <= 1'b0;
        end else begin
            src_flag <= next_src_flag;
            level <= next_level;
            high_level_global_enable <= next_hi_en;
            low_level_global_enable <= next_lo_en;
            ret_stack <= next_ret_stack;
            vector_take <= next_vector_take;
            vector_addr <= next_vector_addr;
            stack_push <= next_stack_push;
            stack_push_data <= next_stack_push_data;
            in_high_handler <= (next_level == TLIC_IN_HIGH) || (next_level == TLIC_IN_BOTH);
            in_low_handler <= (next_level == TLIC_IN_LOW) || (next_level == TLIC_IN_BOTH);
        end
    end

    // Each take gives the core a one-cycle load strobe; a parked pin edge moves only at boundaries.
    sequence s_vector_pulse;
        vector_take ##1 !vector_take;
    endsequence

    sequence s_pin_parked;
        pin_seen[0] && !instr_boundary;
    endsequence

    sequence s_pin_released;
        pin_stage[0] && instr_boundary;
    endsequence

    AST_VEC_PUSH_PAIR: assert property (@(posedge clk_sys) disable iff (rst)
        vector_take |-> stack_push) else $error("vector without push");
    AST_TAKE_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
        sel.take |=> s_vector_pulse) else $error("vector strobe not one cycle");
    AST_HI_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(in_high_handler) && priority_mode_enable |-> vector_addr == `TLIC_VEC_HIGH)
        else $error("high vector wrong");
    AST_LO_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
        vector_take && priority_mode_enable && $rose(in_low_handler) |-> vector_addr == `TLIC_VEC_LOW)
        else $error("low vector wrong");
    AST_COMPAT_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
        vector_take && !$past(priority_mode_enable) |-> vector_addr == `TLIC_VEC_HIGH)
        else $error("compat vector wrong");
    AST_CLEAR_ON_TAKE: assert property (@(posedge clk_sys) disable iff (rst)
        sel.take && sel.high |=> !high_level_global_enable) else $error("enable not cleared");
    AST_LO_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        sel.take && !sel.high && prio_mode |=> !low_level_global_enable)
        else $error("low enable not cleared");
    AST_NO_LO_IN_HI: assert property (@(posedge clk_sys) disable iff (rst)
        prio_mode && in_high_handler |-> !(sel.take && !sel.high)) else $error("low taken in high");
    AST_HI_GATE: assert property (@(posedge clk_sys) disable iff (rst)
        prio_mode && !high_level_global_enable |-> !(sel.take && sel.high))
        else $error("high taken while gated");
    AST_LO_GATE: assert property (@(posedge clk_sys) disable iff (rst)
        prio_mode && !low_level_global_enable |-> !(sel.take && !sel.high))
        else $error("low taken while gated");
    AST_COMPAT_GATE: assert property (@(posedge clk_sys) disable iff (rst)
        !prio_mode && (!high_level_global_enable || (!low_level_global_enable
        && (src_flag & src_enable & ~src_is_periph) == '0)) |-> !sel.take) else $error("compat gate open");
    AST_PREEMPT: assert property (@(posedge clk_sys) disable iff (rst)
        in_low_handler && !in_high_handler && req_hi && instr_boundary && !vector_take
        |=> vector_take && in_high_handler) else $error("high did not preempt low");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst)
        periph_event[0] |=> src_flag[0]) else $error("flag lost");
    AST_PIN_PARKED: assert property (@(posedge clk_sys) disable iff (rst)
        s_pin_parked |=> pin_seen[0]) else $error("pin event moved off boundary");
    AST_PIN_RELEASED: assert property (@(posedge clk_sys) disable iff (rst)
        s_pin_released |=> src_flag[0]) else $error("pin event did not set flag");
    AST_MASKED: assert property (@(posedge clk_sys) disable iff (rst)
        (src_enable & src_flag) == '0 |-> !sel.take) else $error("masked source vectored");
    AST_BOUNDARY: assert property (@(posedge clk_sys) disable iff (rst)
        vector_take |-> $past(instr_boundary)) else $error("vector off boundary");
    AST_HI_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
        vector_take && $past(req_hi) |-> vector_addr == `TLIC_VEC_HIGH && in_high_handler)
        else $error("low before high");
    AST_RET_SETS: assert property (@(posedge clk_sys) disable iff (rst)
        return_from_handler_instr && !sel.take && ret_stack[0] && !global_clr_hi
        |=> high_level_global_enable) else $error("return did not re-enable");
    AST_RET_LO: assert property (@(posedge clk_sys) disable iff (rst)
        return_from_handler_instr && !sel.take && !ret_stack[0] && !global_clr_lo
        |=> low_level_global_enable) else $error("return did not re-enable low");
endmodule : tlic_top

// ===== sim/tlic_core_model.sv
`timescale 1ns/10ps
`include "tlic_regs.svh"
module tlic_core_model (
    input wire logic clk_sys, // Core clock.
    input wire logic rst, // Asynchronous reset.
    input wire logic ret_req, // Asks for a return.
    output logic instr_boundary, // Every fourth clock.
    output logic return_from_handler_instr, // Return pulse.
    output logic [`TLIC_PC_W-1:0] return_pc // Next address.
);
    logic [1:0] phase, next_phase;
    logic pend, next_pend, next_bnd, next_ret;
    logic [`TLIC_PC_W-1:0] next_pc;
    // A return pulses only one clock after an instruction boundary, never on one.
    always_comb begin
        next_phase = phase + 2'h1;
        next_bnd = (phase == 2'h3);
        next_ret = instr_boundary && (pend || ret_req);
        next_pend = (pend || ret_req) && !instr_boundary;
        next_pc = instr_boundary ? return_pc + 21'h2 : return_pc;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
            pend <= 1'h0;
            instr_boundary <= 1'h0;
            return_from_handler_instr <= 1'h0;
            return_pc <= 21'h000100;
        end else begin
            phase <= next_phase;
            pend <= next_pend;
            instr_boundary <= next_bnd;
            return_from_handler_instr <= next_ret;
            return_pc <= next_pc;
        end
    end
endmodule : tlic_core_model

// ===== sim/tb_two_level_interrupt_priority_ctrl.sv
`timescale 1ns/10ps
`include "tlic_regs.svh"
module tb_two_level_interrupt_priority_ctrl;
    import tlic_pkg::*;
    logic clk_sys, rst, ret_req, instr_boundary, ret_instr;
    logic [3:0] pin_event_in, pin_rising;
    logic [7:0] periph_event, src_is_periph, src_enable, src_priority, flag_clear, src_flag;
    logic priority_mode_enable, gsh, gch, gsl, gcl, hi_en, lo_en;
    logic vector_take, stack_push, in_high, in_low;
    logic [20:0] return_pc, vector_addr, push_data, last_pc;
    int failures, compares, lat;

    tlic_core_model i_tlic_core_model (.clk_sys(clk_sys), .rst(rst), .ret_req(ret_req),
        .instr_boundary(instr_boundary), .return_from_handler_instr(ret_instr), .return_pc(return_pc));
    tlic_top i_tlic_top (.clk_sys(clk_sys), .rst(rst), .instr_boundary(instr_boundary),
        .pin_event_in(pin_event_in), .pin_rising(pin_rising), .periph_event(periph_event),
        .src_is_periph(src_is_periph), .src_enable(src_enable), .src_priority(src_priority),
        .flag_clear(flag_clear), .priority_mode_enable(priority_mode_enable),
        .global_set_hi(gsh), .global_clr_hi(gch), .global_set_lo(gsl), .global_clr_lo(gcl),
        .return_from_handler_instr(ret_instr), .return_pc(return_pc), .src_flag(src_flag),
        .high_level_global_enable(hi_en), .low_level_global_enable(lo_en),
        .vector_take(vector_take), .vector_addr(vector_addr), .stack_push(stack_push),
        .stack_push_data(push_data), .in_high_handler(in_high), .in_low_handler(in_low));

    // Address the core offered at the last boundary, which is the one a take pushes.
    always @(posedge clk_sys) begin
        if (instr_boundary === 1'h1) last_pc <= return_pc;
    end

    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // Control bits change only through single write pulses.
    task automatic pulse(input logic [7:0] ev, input logic [7:0] fc, input logic [3:0] g);
        @(negedge clk_sys);
        periph_event = ev;
        flag_clear = fc;
        {gsh, gch, gsl, gcl} = g;
        @(negedge clk_sys);
        periph_event = 8'h00;
        flag_clear = 8'h00;
        {gsh, gch, gsl, gcl} = 4'h0;
    endtask : pulse

    task automatic wait_take(input logic [20:0] exp);
        lat = 0;
        while (vector_take !== 1'h1 && lat < 40) begin
            @(negedge clk_sys);
            lat++;
        end
        if (lat >= 40) begin
            failures++;
            $display("CHECK FAILED at %0t: no vector taken", $time);
            end_sim();
        end
        chk(vector_addr, exp, "vector address");
        chk(stack_push, 1'h1, "push strobe");
        chk(push_data, last_pc, "pushed address");
    endtask : wait_take

    task automatic no_take(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (vector_take !== 1'h0) hits++;
        end
        chk(hits, 0, "unexpected vector");
    endtask : no_take

    task automatic do_ret();
        int n;
        n = 0;
        @(negedge clk_sys);
        ret_req = 1'h1;
        @(negedge clk_sys);
        ret_req = 1'h0;
        while (ret_instr !== 1'h1 && n < 10) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 10) begin
            failures++;
            $display("CHECK FAILED at %0t: return never ran", $time);
            end_sim();
        end
        @(negedge clk_sys);
    endtask : do_ret

    task automatic t_reset();
        chk(vector_addr, `TLIC_VEC_HIGH, "reset address");
        chk({hi_en, lo_en, vector_take, stack_push, in_high, in_low}, 6'h00, "reset state");
        chk(src_flag, 8'h00, "reset flags");
        $display("test reset done");
    endtask : t_reset

    task automatic t_compat();
        priority_mode_enable = 1'h0;
        src_is_periph = 8'h02;
        src_enable = 8'h03;
        src_priority = 8'h02;
        pulse(8'h02, 8'h00, 4'h8);
        chk(src_flag[1], 1'h1, "flag set while gated");
        no_take(12);
        pulse(8'h00, 8'h00, 4'h2);
        wait_take(`TLIC_VEC_HIGH);
        chk(hi_en, 1'h0, "single enable cleared");
        pulse(8'h00, 8'h02, 4'h0);
        do_ret();
        chk(hi_en, 1'h1, "single enable restored");
        $display("test compat done");
    endtask : t_compat

    task automatic t_prio();
        pulse(8'h00, 8'h00, 4'h5);
        priority_mode_enable = 1'h1;
        src_priority = 8'h01;
        src_is_periph = 8'h00;
        pulse(8'h00, 8'h00, 4'ha);
        pulse(8'h02, 8'h00, 4'h0);
        wait_take(`TLIC_VEC_LOW);
        chk({hi_en, lo_en, in_low}, 3'h5, "low entry");
        pulse(8'h01, 8'h00, 4'h0);
        wait_take(`TLIC_VEC_HIGH);
        chk({hi_en, in_high}, 2'h1, "high entry");
        pulse(8'h00, 8'h03, 4'h0);
        do_ret();
        chk({hi_en, in_high, in_low}, 3'h5, "high return");
        do_ret();
        chk({lo_en, in_low}, 2'h2, "low return");
        $display("test priority done");
    endtask : t_prio

    task automatic t_both();
        src_enable = 8'h02;
        pulse(8'h01, 8'h00, 4'h0);
        no_take(12);
        chk(src_flag[0], 1'h1, "flag set while disabled");
        pulse(8'h00, 8'h01, 4'h0);
        src_enable = 8'h03;
        pulse(8'h03, 8'h00, 4'h0);
        wait_take(`TLIC_VEC_HIGH);
        no_take(12);
        pulse(8'h00, 8'h01, 4'h0);
        do_ret();
        wait_take(`TLIC_VEC_LOW);
        pulse(8'h00, 8'h02, 4'h0);
        do_ret();
        $display("test simultaneous done");
    endtask : t_both

    task automatic t_pin();
        src_enable = 8'h01;
        pin_rising = 4'h1;
        // First a rising edge, then a falling edge with the edge select turned round.
        for (int e = 0; e < 2; e++) begin
            @(negedge clk_sys);
            pin_event_in = (e == 0) ? 4'h1 : 4'h0;
            wait_take(`TLIC_VEC_HIGH);
            chk(lat >= 12 && lat <= 16, 1'h1, "pin latency");
            pulse(8'h00, 8'h01, 4'h0);
            do_ret();
            pin_rising = 4'h0;
        end
        $display("test pin done");
    endtask : t_pin

    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        failures = 0;
        compares = 0;
        rst = 1'h1;
        ret_req = 1'h0;
        pin_event_in = 4'h0;
        pin_rising = 4'h0;
        {periph_event, src_is_periph, src_enable, src_priority, flag_clear} = 40'h0;
        priority_mode_enable = 1'h0;
        {gsh, gch, gsl, gcl} = 4'h0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'h0;
        t_reset();
        t_compat();
        t_prio();
        t_both();
        t_pin();
        end_sim();
    end
endmodule : tb_two_level_interrupt_priority_ctrl
